// [see_defines.vh]
// constants for the string edit engine: register map, fields, operator codes
// Behaviour
// - forward skip advances pointer, faults odd-tagged words
// - forward skip rotates source operand left
// - source skip via pointer-update entry undefined
// - reverse skip decrements; underflow faults, pointer 8000:0
// - reverse skip rotates source operand right
// - negative length is zero; read-only skippable
// - inserts protect read-only; hex keeps numeric field
// - repeat insert writes parameter length times
// - selected insert picks zero/nonzero by float
// - overpunch sets zone D when sign; advances
// - sign insert picks minus/plus; hex faults
// - end float stores sign if float clear
// - moves: pointer-update entry undefined; protect; hex numeric
// - move chars copies length characters unchanged
// - move numeric forces zone F
// - zero suppress move sets float on nonzero
// - signed suppress inserts sign before first digit
// - signed suppress stores length plus one if float clear and a digit nonzero
// - clear float op clears float flag
// - end edit leaves table mode, pushes results
// - FE no action; DF halts when enabled
// - FF raises invalid operator fault
// - single mode length below one means zero
`ifndef SEE_DEFINES_VH
`define SEE_DEFINES_VH
// =====================================================================
// register byte offsets
`define SEE_A_CTRL 8'h00
`define SEE_A_STATUS 8'h04
`define SEE_A_LEN 8'h08
`define SEE_A_PARAM 8'h0C
`define SEE_A_SPTR 8'h10
`define SEE_A_DPTR 8'h14
`define SEE_A_OPND_HI 8'h18
`define SEE_A_OPND_LO 8'h1C
`define SEE_A_MEM_ADDR 8'h20
`define SEE_A_MEM_LO 8'h24
`define SEE_A_MEM_HI 8'h28
`define SEE_A_RES_TOP 8'h2C
`define SEE_A_RES_SEC 8'h30
// =====================================================================
// control fields
`define SEE_C_OP_HI 7
`define SEE_C_START 8
`define SEE_C_TABLE 9
`define SEE_C_PTR_UPD 10
`define SEE_C_SRC_OPND 11
`define SEE_C_SRC_HEX 12
`define SEE_C_DST_HEX 13
`define SEE_C_DST_RO 14
`define SEE_C_HALT_EN 15
`define SEE_C_UPDATE 16
`define SEE_C_EXT_SIGN 17
// status fields
`define SEE_S_BUSY 0
`define SEE_S_FLOAT 1
`define SEE_S_TABLE 2
`define SEE_S_RESV 3
`define SEE_S_HALTED 4
`define SEE_S_FLT_LO 8
`define SEE_S_FLT_HI 12
// fault vector bits
`define SEE_F_PAGED 0
`define SEE_F_MPROT 1
`define SEE_F_STKARG 2
`define SEE_F_UNDEF 3
`define SEE_F_INVOP 4
// parameter character bytes
`define SEE_PR_CHAR 7:0
`define SEE_PR_NZ 15:8
`define SEE_PR_MINUS 23:16
`define SEE_PR_PLUS 31:24
// pointer fields: word index and character index
`define SEE_P_WORD 19:4
`define SEE_P_CHAR 3:0
`define SEE_P_MEMSEL 9:4
`define SEE_FAULT_PTR 20'h8_0000
`define SEE_HEX_LAST 4'hB
`define SEE_EBC_LAST 4'h5
`define SEE_WORD_MSB 47
`define SEE_ZONE_F 4'hF
`define SEE_ZONE_D 4'hD
// =====================================================================
// operator codes
`define SEE_OP_MOVE_ZERO_SUPPRESS 8'hD0
`define SEE_OP_MOVE_SIGNED_SUPPRESS 8'hD1
`define SEE_OP_SKIP_FWD_SOURCE 8'hD2
`define SEE_OP_SKIP_REV_SOURCE 8'hD3
`define SEE_OP_CLEAR_FLOAT_FLAG 8'hD4
`define SEE_OP_END_FLOAT_SIGN 8'hD5
`define SEE_OP_MOVE_NUMERIC_FIELDS 8'hD6
`define SEE_OP_MOVE_CHARS 8'hD7
`define SEE_OP_INSERT_OVERPUNCH_ZONE 8'hD8
`define SEE_OP_INSERT_SIGN_CHAR 8'hD9
`define SEE_OP_SKIP_FWD_DEST 8'hDA
`define SEE_OP_SKIP_REV_DEST 8'hDB
`define SEE_OP_INSERT_REPEAT 8'hDC
`define SEE_OP_INSERT_SELECTED 8'hDD
`define SEE_OP_END_TABLE_EDIT 8'hDE
`define SEE_OP_COND_HALT 8'hDF
`define SEE_OP_NO_ACTION 8'hFE
`define SEE_OP_INVALID 8'hFF
`define SEE_OP_EDIT_GROUP 4'hD
`endif

// [see_edit_engine.v]
// string edit engine with avalon-mm register slave and local character store
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "see_defines.vh"
module see_edit_engine (
   input wire clk, // processor clock
   input wire nrst, // async reset, active low
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   output reg [31:0] avs_readdata, // read data
   output reg avs_waitrequest, // low one cycle to answer
   output reg halt_o, // processor halted
   output reg busy_o // operator running
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;
   // =====================================================================
   // state and registers
   reg [17:0] ctrl_r; // control fields
   reg start_r; // launch request pulse
   reg [15:0] len_r; // signed length
   reg [31:0] par_r; // parameter characters
   reg [19:0] sptr_r; // source pointer
   reg [19:0] dptr_r; // destination pointer
   reg [47:0] opnd_r; // source operand
   reg [5:0] maddr_r; // store window address
   reg [19:0] res_top_r; // pushed source
   reg [19:0] res_sec_r; // pushed destination
   reg float_r; // float flag
   reg tact_r; // table edit mode active
   reg resv_r; // results pushed
   reg [4:0] flt_r; // sticky faults
   reg st_r; // engine state
   reg [7:0] op_r; // running operator
   reg [15:0] cnt_r; // characters left
   reg [47:0] mem_d [0:63]; // character words
   reg [2:0] mem_t [0:63]; // word tags

   // =====================================================================
   // helper functions
   // character at index, left justified
   function [7:0] get_ch;
      input [47:0] w;
      input [3:0] idx;
      input hx;
      begin
         if (hx)
            get_ch = {4'h0, w[`SEE_WORD_MSB - 4 * idx -: 4]};
         else
            get_ch = w[`SEE_WORD_MSB - 8 * idx -: 8];
      end
   endfunction
   // replace one character; hex keeps numeric field only
   function [47:0] put_ch;
      input [47:0] w;
      input [3:0] idx;
      input hx;
      input [7:0] ch;
      begin
         put_ch = w;
         if (hx)
            put_ch[`SEE_WORD_MSB - 4 * idx -: 4] = ch[3:0];
         else
            put_ch[`SEE_WORD_MSB - 8 * idx -: 8] = ch;
      end
   endfunction

   // pointer advanced by one character
   function [19:0] ptr_inc;
      input [19:0] p;
      input hx;
      begin
         if (p[`SEE_P_CHAR] == (hx ? `SEE_HEX_LAST : `SEE_EBC_LAST))
            ptr_inc = {p[`SEE_P_WORD] + 16'h0001, 4'h0};
         else
            ptr_inc = {p[`SEE_P_WORD], p[`SEE_P_CHAR] + 4'h1};
      end
   endfunction

   // pointer backed by one character, msb flags underflow
   function [20:0] ptr_dec;
      input [19:0] p;
      input hx;
      begin
         if (p[`SEE_P_CHAR] != 4'h0)
            ptr_dec = {1'b0, p[`SEE_P_WORD], p[`SEE_P_CHAR] - 4'h1};
         else if (p[`SEE_P_WORD] == 16'h0000)
            ptr_dec = {1'b1, `SEE_FAULT_PTR};
         else
            ptr_dec = {1'b0, p[`SEE_P_WORD] - 16'h0001,
                       (hx ? `SEE_HEX_LAST : `SEE_EBC_LAST)};
      end
   endfunction

   // circular rotation of the operand by one character
   function [47:0] rot;
      input [47:0] w;
      input hx;
      input left;
      begin
         if (left)
            rot = hx ? {w[43:0], w[47:44]} : {w[39:0], w[47:40]};
         else
            rot = hx ? {w[3:0], w[47:4]} : {w[7:0], w[47:8]};
      end
   endfunction

   // =====================================================================
   // decode of control and operands
   wire [7:0] c_op = ctrl_r[`SEE_C_OP_HI:0];
   wire s_opnd = ctrl_r[`SEE_C_SRC_OPND];
   wire d_hex = ctrl_r[`SEE_C_DST_HEX];
   wire s_hex = s_opnd ? d_hex : ctrl_r[`SEE_C_SRC_HEX];
   wire ext_sign = ctrl_r[`SEE_C_EXT_SIGN];
   wire [15:0] len_eff = len_r[15] ? 16'h0000 : len_r;
   wire [47:0] sw = mem_d[sptr_r[`SEE_P_MEMSEL]];
   wire [47:0] dw = mem_d[dptr_r[`SEE_P_MEMSEL]];
   wire s_pg = mem_t[sptr_r[`SEE_P_MEMSEL]][0]; // odd tag
   wire d_pg = mem_t[dptr_r[`SEE_P_MEMSEL]][0];
   wire [7:0] sch = s_opnd ? get_ch(opnd_r, 4'h0, s_hex)
                           : get_ch(sw, sptr_r[`SEE_P_CHAR], s_hex);
   wire [7:0] dch = get_ch(dw, dptr_r[`SEE_P_CHAR], d_hex);
   wire [20:0] rs = ptr_dec(sptr_r, s_hex);
   wire [20:0] rd = ptr_dec(dptr_r, d_hex);
   wire [7:0] sign_ch = ext_sign ? par_r[`SEE_PR_MINUS] : par_r[`SEE_PR_PLUS];
   wire [7:0] digit = {`SEE_ZONE_F, sch[3:0]};
   wire wr_go = avs_write & ~avs_waitrequest;

   // operator classes seen at launch
   wire is_skip_src = (c_op == `SEE_OP_SKIP_FWD_SOURCE) || (c_op == `SEE_OP_SKIP_REV_SOURCE);
   wire is_skip = is_skip_src || (c_op == `SEE_OP_SKIP_FWD_DEST)
                  || (c_op == `SEE_OP_SKIP_REV_DEST);
   wire is_move = (c_op == `SEE_OP_MOVE_ZERO_SUPPRESS) || (c_op == `SEE_OP_MOVE_SIGNED_SUPPRESS)
                  || (c_op == `SEE_OP_MOVE_NUMERIC_FIELDS) || (c_op == `SEE_OP_MOVE_CHARS);
   wire is_ins = (c_op == `SEE_OP_INSERT_REPEAT) || (c_op == `SEE_OP_INSERT_SELECTED)
                 || (c_op == `SEE_OP_INSERT_OVERPUNCH_ZONE)
                 || (c_op == `SEE_OP_INSERT_SIGN_CHAR)
                 || ((c_op == `SEE_OP_END_FLOAT_SIGN) && !float_r);
   wire known = (c_op[7:4] == `SEE_OP_EDIT_GROUP) || (c_op == `SEE_OP_NO_ACTION)
                || (c_op == `SEE_OP_INVALID);
   wire one_char = (c_op == `SEE_OP_INSERT_OVERPUNCH_ZONE) || (c_op == `SEE_OP_INSERT_SIGN_CHAR)
                   || ((c_op == `SEE_OP_END_FLOAT_SIGN) && !float_r);

   // =====================================================================
   // launch checks and per-character datapath
   reg [4:0] fset; // faults raised now
   reg do_wr; // store a destination character
   reg [7:0] wr_ch; // character to store
   reg adv_s; // source forward one
   reg adv_d; // destination forward one
   reg rev_s; // source back one
   reg rev_d; // destination back one
   reg use_cnt; // step consumes length
   reg flt_set; // set float flag
   reg st_nxt; // next engine state
   always @*
   begin
      fset = 5'h00;
      do_wr = 1'b0;
      wr_ch = par_r[`SEE_PR_CHAR];
      adv_s = 1'b0;
      adv_d = 1'b0;
      rev_s = 1'b0;
      rev_d = 1'b0;
      use_cnt = 1'b1;
      flt_set = 1'b0;
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:
         begin
            if (start_r)
            begin
               // pointer-update entry cannot run source skips or moves
               fset[`SEE_F_UNDEF] = (ctrl_r[`SEE_C_PTR_UPD] && (is_skip_src || is_move))
                                    || !known;
               fset[`SEE_F_INVOP] = (c_op == `SEE_OP_INVALID);
               fset[`SEE_F_STKARG] = ((is_skip || is_move || is_ins) && !s_opnd
                                      && (ctrl_r[`SEE_C_SRC_HEX] != d_hex))
                                     || (((c_op == `SEE_OP_INSERT_OVERPUNCH_ZONE)
                                     || (c_op == `SEE_OP_INSERT_SIGN_CHAR)) && d_hex);
               // read-only destination refused for stores, allowed for skips
               fset[`SEE_F_MPROT] = (is_move || is_ins) && ctrl_r[`SEE_C_DST_RO];
               if ((fset == 5'h00) && (one_char || ((is_skip || is_move
                   || (is_ins && !one_char)) && (len_eff != 16'h0000))))
                  st_nxt = ST_RUN;
            end
         end
         ST_RUN:
         begin
            case (op_r)
               `SEE_OP_SKIP_FWD_SOURCE: adv_s = 1'b1;
               `SEE_OP_SKIP_FWD_DEST: adv_d = 1'b1;
               `SEE_OP_SKIP_REV_SOURCE: rev_s = 1'b1;
               `SEE_OP_SKIP_REV_DEST: rev_d = 1'b1;
               `SEE_OP_INSERT_REPEAT:
               begin
                  do_wr = 1'b1;
                  adv_d = 1'b1;
               end
               `SEE_OP_INSERT_SELECTED:
               begin
                  do_wr = 1'b1;
                  adv_d = 1'b1;
                  wr_ch = float_r ? par_r[`SEE_PR_NZ] : par_r[`SEE_PR_CHAR];
               end
               `SEE_OP_INSERT_OVERPUNCH_ZONE:
               begin
                  do_wr = 1'b1;
                  adv_d = 1'b1;
                  wr_ch = ext_sign ? {`SEE_ZONE_D, dch[3:0]} : dch;
               end
               `SEE_OP_INSERT_SIGN_CHAR, `SEE_OP_END_FLOAT_SIGN:
               begin
                  do_wr = 1'b1;
                  adv_d = 1'b1;
                  wr_ch = sign_ch;
               end
               `SEE_OP_MOVE_CHARS:
               begin
                  do_wr = 1'b1;
                  adv_s = 1'b1;
                  adv_d = 1'b1;
                  wr_ch = sch;
               end
               `SEE_OP_MOVE_NUMERIC_FIELDS:
               begin
                  do_wr = 1'b1;
                  adv_s = 1'b1;
                  adv_d = 1'b1;
                  wr_ch = digit; // hex store keeps the nibble only
               end
               `SEE_OP_MOVE_ZERO_SUPPRESS, `SEE_OP_MOVE_SIGNED_SUPPRESS:
               begin
                  do_wr = 1'b1;
                  adv_d = 1'b1;
                  if (!float_r && (sch[3:0] == 4'h0))
                  begin
                     adv_s = 1'b1; // zero while no float
                     wr_ch = par_r[`SEE_PR_CHAR];
                  end
                  else if (!float_r && (op_r == `SEE_OP_MOVE_SIGNED_SUPPRESS))
                  begin
                     wr_ch = sign_ch; // extra sign, source held
                     use_cnt = 1'b0;
                     flt_set = 1'b1;
                  end
                  else
                  begin
                     adv_s = 1'b1;
                     flt_set = 1'b1;
                     wr_ch = digit;
                  end
               end
               default: do_wr = 1'b0;
            endcase
            // odd tags passed over or written, or reverse underflow
            fset[`SEE_F_PAGED] = (adv_s && !s_opnd && s_pg) || (adv_d && d_pg)
                                 || (rev_s && !s_opnd && rs[20]) || (rev_d && rd[20]);
            if ((fset != 5'h00) || (cnt_r == {15'h0000, use_cnt}))
               st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // =====================================================================
   // register read mux
   reg [31:0] rd_val;
   always @*
   begin
      case (avs_address)
         `SEE_A_CTRL: rd_val = {14'h0000, ctrl_r};
         `SEE_A_STATUS: rd_val = {19'h0_0000, flt_r, 3'h0, halt_o, resv_r, tact_r, float_r, st_r};
         `SEE_A_LEN: rd_val = {16'h0000, len_r};
         `SEE_A_PARAM: rd_val = par_r;
         `SEE_A_SPTR: rd_val = {12'h000, sptr_r};
         `SEE_A_DPTR: rd_val = {12'h000, dptr_r};
         `SEE_A_OPND_HI: rd_val = {16'h0000, opnd_r[47:32]};
         `SEE_A_OPND_LO: rd_val = opnd_r[31:0];
         `SEE_A_MEM_ADDR: rd_val = {26'h000_0000, maddr_r};
         `SEE_A_MEM_LO: rd_val = mem_d[maddr_r][31:0];
         `SEE_A_MEM_HI: rd_val = {13'h0000, mem_t[maddr_r], mem_d[maddr_r][47:32]};
         `SEE_A_RES_TOP: rd_val = {12'h000, res_top_r};
         `SEE_A_RES_SEC: rd_val = {12'h000, res_sec_r};
         default: rd_val = 32'h0000_0000; // unmapped reads zero
      endcase
   end

   // =====================================================================
   // character store: engine writes while running, bus while idle
   always @(posedge clk)
   begin
      if ((st_r == ST_RUN) && do_wr && (fset == 5'h00))
         mem_d[dptr_r[`SEE_P_MEMSEL]] <= put_ch(dw, dptr_r[`SEE_P_CHAR], d_hex, wr_ch);
      else if (wr_go && (st_r == ST_IDLE) && (avs_address == `SEE_A_MEM_LO))
         mem_d[maddr_r][31:0] <= avs_writedata;
      else if (wr_go && (st_r == ST_IDLE) && (avs_address == `SEE_A_MEM_HI))
      begin
         mem_d[maddr_r][47:32] <= avs_writedata[15:0];
         mem_t[maddr_r] <= avs_writedata[18:16];
      end
   end

   // =====================================================================
   // bus handshake, registers and engine sequencing
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         halt_o <= 1'b0;
         busy_o <= 1'b0;
         ctrl_r <= 18'h0_0000;
         start_r <= 1'b0;
         len_r <= 16'h0000;
         par_r <= 32'h0000_0000;
         sptr_r <= 20'h0_0000;
         dptr_r <= 20'h0_0000;
         opnd_r <= 48'h0000_0000_0000;
         maddr_r <= 6'h00;
         res_top_r <= 20'h0_0000;
         res_sec_r <= 20'h0_0000;
         float_r <= 1'b0;
         tact_r <= 1'b0;
         resv_r <= 1'b0;
         flt_r <= 5'h00;
         st_r <= ST_IDLE;
         op_r <= 8'h00;
         cnt_r <= 16'h0000;
      end
      else
      begin
         // one wait cycle, then answer
         if ((avs_read || avs_write) && avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_val;
         end
         else
            avs_waitrequest <= 1'b1;
         st_r <= st_nxt;
         busy_o <= (st_nxt == ST_RUN);
         start_r <= 1'b0;
         // sticky faults: a new fault wins over a clear
         if (wr_go && (avs_address == `SEE_A_STATUS))
            flt_r <= (flt_r & ~avs_writedata[`SEE_S_FLT_HI:`SEE_S_FLT_LO]) | fset;
         else
            flt_r <= flt_r | fset;
         // software writes, refused while running
         if (wr_go && (st_r == ST_IDLE))
         begin
            case (avs_address)
               `SEE_A_CTRL:
               begin
                  ctrl_r <= avs_writedata[17:0] & ~(18'h0_0001 << `SEE_C_START);
                  start_r <= avs_writedata[`SEE_C_START] && !start_r;
               end
               `SEE_A_STATUS:
               begin
                  if (avs_writedata[`SEE_S_RESV])
                     resv_r <= 1'b0;
                  if (avs_writedata[`SEE_S_HALTED])
                     halt_o <= 1'b0;
               end
               `SEE_A_LEN: len_r <= avs_writedata[15:0];
               `SEE_A_PARAM: par_r <= avs_writedata;
               `SEE_A_SPTR: sptr_r <= avs_writedata[19:0];
               `SEE_A_DPTR: dptr_r <= avs_writedata[19:0];
               `SEE_A_OPND_HI: opnd_r[47:32] <= avs_writedata[15:0];
               `SEE_A_OPND_LO: opnd_r[31:0] <= avs_writedata;
               `SEE_A_MEM_ADDR: maddr_r <= avs_writedata[5:0];
               default: ;
            endcase
         end
         // launch of an operator
         if ((st_r == ST_IDLE) && start_r && (fset == 5'h00))
         begin
            op_r <= c_op;
            cnt_r <= one_char ? 16'h0001 : len_eff;
            if (ctrl_r[`SEE_C_TABLE] && (c_op != `SEE_OP_END_TABLE_EDIT))
               tact_r <= 1'b1;
            case (c_op)
               `SEE_OP_COND_HALT:
                  if (ctrl_r[`SEE_C_HALT_EN])
                     halt_o <= 1'b1;
               `SEE_OP_CLEAR_FLOAT_FLAG: float_r <= 1'b0;
               `SEE_OP_END_FLOAT_SIGN: float_r <= 1'b0; // stores only when clear
               `SEE_OP_END_TABLE_EDIT:
               begin
                  tact_r <= 1'b0;
                  if (ctrl_r[`SEE_C_UPDATE])
                  begin
                     res_top_r <= sptr_r; // source on top
                     res_sec_r <= dptr_r;
                     resv_r <= 1'b1;
                  end
               end
               default: ; // no action code and others
            endcase
         end
         // one character per cycle while running
         if (st_r == ST_RUN)
         begin
            cnt_r <= cnt_r - {15'h0000, use_cnt};
            if (rev_s)
            begin
               if (s_opnd)
                  opnd_r <= rot(opnd_r, s_hex, 1'b0);
               else
                  sptr_r <= rs[19:0]; // faulting pointer kept
            end
            if (rev_d)
               dptr_r <= rd[19:0];
            if (fset == 5'h00)
            begin
               if (adv_s && s_opnd)
                  opnd_r <= rot(opnd_r, s_hex, 1'b1);
               else if (adv_s)
                  sptr_r <= ptr_inc(sptr_r, s_hex);
               if (adv_d)
                  dptr_r <= ptr_inc(dptr_r, d_hex);
               if (flt_set)
                  float_r <= 1'b1;
            end
         end
      end
   end
endmodule

// [see_edit_props.sv]
// port checker for the string edit engine
`timescale 1ns/1ns
`include "see_defines.vh"
module see_edit_props (
   input wire clk, // clock
   input wire nrst, // reset, active low
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [31:0] avs_readdata, // read data
   input wire avs_waitrequest, // slave wait
   input wire halt_o, // halted
   input wire busy_o // operator running
);
   // ==========
   // launch decode
   wire wr_done = avs_write && !avs_waitrequest; // write takes effect
   wire start = wr_done && avs_address == `SEE_A_CTRL && avs_writedata[8]; // launch
   wire [7:0] op = avs_writedata[7:0]; // launched code
   wire halt_go = start && op == `SEE_OP_COND_HALT && avs_writedata[15]; // enabled halt
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========
   // bus timing
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("answer without request");
   // ==========
   // engine outputs tied to their causes
   a_busy_cause: assert property ($rose(busy_o) |-> $past(start) || $past(start, 2)
      || $past(start, 3)) else $error("busy without launch");
   a_halt_cause: assert property ($rose(halt_o) |-> $past(halt_go) || $past(halt_go, 2)
      || $past(halt_go, 3)) else $error("halt without enabled halt code");
   a_halt_hold: assert property (halt_o && !(wr_done && avs_address == `SEE_A_STATUS
      && avs_writedata[4]) |=> halt_o) else $error("halt dropped without clear");
   a_halt_disabled: assert property (start && op == `SEE_OP_COND_HALT && !avs_writedata[15]
      && !halt_o |=> !halt_o [*3]) else $error("halt while disabled");
   a_invalid_idle: assert property (start && op == `SEE_OP_INVALID && !busy_o
      |=> !busy_o [*3]) else $error("invalid code ran");
   a_clear_idle: assert property (start && op == `SEE_OP_CLEAR_FLOAT_FLAG && !busy_o
      |=> !busy_o [*3]) else $error("float clear ran");
   c_busy: cover property ($rose(busy_o));
   c_halt: cover property ($rose(halt_o));
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind see_edit_engine see_edit_props see_edit_props_i (.clk(clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .halt_o(halt_o), .busy_o(busy_o));

// [see_store_model.sv]
// expected image of the character store behind the edit engine
`timescale 1ns/1ns
module see_store_model;
   // ==========
   // word image, char 0 leftmost
   reg [47:0] img [0:63]; // expected store words
endmodule

// [testbench.sv]
// self-checking bench for the string edit engine
`timescale 1ns/1ns
`include "see_defines.vh"
`define CK(x, e) samples_checked += 1; if ((x) !== (e)) miss(x, e);
module testbench;
   reg clk = 1'b0; // clock
   reg nrst = 1'b0; // reset
   reg [7:0] avs_address = 8'h00; // address
   reg avs_read = 1'b0; // read
   reg avs_write = 1'b0; // write
   reg [31:0] avs_writedata = 32'h0; // write data
   wire [31:0] avs_readdata; // read data
   wire avs_waitrequest, halt_o, busy_o; // outputs
   reg [31:0] rdv; // last read value
   integer bad_count = 0, samples_checked = 0, i;
   // launch codes tried at start (FF and three refused, FE and DF accepted), and their fault bits
   reg [31:0] fc [0:5] = '{32'h0000_40DC, 32'h0000_04D7, 32'h0000_04D2, 32'h0000_00FF,
      32'h0000_00FE, 32'h0000_00DF};
   reg [31:0] fe [0:5] = '{32'h0000_0200, 32'h0000_0800, 32'h0000_0800, 32'h0000_1000,
      32'h0, 32'h0};
   see_edit_engine see_edit_engine_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_o(halt_o),
      .busy_o(busy_o));
   see_store_model see_store_model_i ();
   always #5 clk = ~clk;
   // ==========
   // bus access: hold until waitrequest is sampled low
   task miss(input [31:0] g, input [31:0] e);
      bad_count += 1;
      $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
   endtask
   task ac(input w, input [7:0] a, input [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clk iff !avs_waitrequest);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input [7:0] a, input [31:0] d);
      ac(1'b1, a, d);
   endtask
   task ck(input [7:0] a, input [31:0] e);
      ac(1'b0, a, 32'h0);
      `CK(rdv, e)
   endtask
   // launch an operator, wait until idle
   task go(input [31:0] c);
      wr(`SEE_A_CTRL, c | 32'h0000_0100);
      repeat (2) @(posedge clk);
      while (busy_o) @(posedge clk);
   endtask
   task mw(input [5:0] w, input [47:0] d, input [2:0] t);
      wr(`SEE_A_MEM_ADDR, {26'h0, w});
      wr(`SEE_A_MEM_LO, d[31:0]);
      wr(`SEE_A_MEM_HI, {13'h0, t, d[47:32]});
      see_store_model_i.img[w] = d;
   endtask
   task mc(input [5:0] w);
      wr(`SEE_A_MEM_ADDR, {26'h0, w});
      ck(`SEE_A_MEM_LO, see_store_model_i.img[w][31:0]);
      ck(`SEE_A_MEM_HI, {16'h0, see_store_model_i.img[w][47:32]});
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #200000;
      bad_count += 1;
      give_verdict;
   end
   // ==========
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      ck(`SEE_A_STATUS, 32'h0);
      mw(6'h00, 48'hF0F0_C1F2_F3F4, 3'h0);
      for (i = 1; i < 5; i = i + 1)
         mw(i[5:0], 48'h4040_4040_4040, (i == 4) ? 3'h1 : 3'h0);
      wr(`SEE_A_PARAM, 32'h4E60_C15C);
      wr(`SEE_A_LEN, 32'h0000_0003);
      wr(`SEE_A_SPTR, 32'h0);
      wr(`SEE_A_DPTR, 32'h0000_0010);
      go(32'h0000_00D7);
      see_store_model_i.img[1] = 48'hF0F0_C140_4040;
      mc(6'h01);
      ck(`SEE_A_DPTR, 32'h0000_0013);
      wr(`SEE_A_SPTR, 32'h0);
      wr(`SEE_A_DPTR, 32'h0000_0020);
      go(32'h0002_00D1);
      ck(`SEE_A_STATUS, 32'h0000_0002);
      ck(`SEE_A_DPTR, 32'h0000_0024);
      wr(`SEE_A_LEN, 32'h0000_0001);
      go(32'h0000_00DD);
      go(32'h0000_00D5);
      ck(`SEE_A_DPTR, 32'h0000_0025);
      ck(`SEE_A_STATUS, 32'h0);
      go(32'h0000_00D5);
      go(32'h0002_00D9);
      go(32'h0002_00D8);
      wr(`SEE_A_LEN, 32'h0000_0002);
      go(32'h0000_00DC);
      wr(`SEE_A_LEN, 32'h0000_0001);
      go(32'h0000_00DD);
      see_store_model_i.img[2] = 48'h5C5C_60F1_C14E;
      see_store_model_i.img[3] = 48'h60D0_5C5C_5C40;
      mc(6'h02);
      mc(6'h03);
      // operand rotation both ways
      wr(`SEE_A_OPND_HI, 32'h0000_0102);
      wr(`SEE_A_OPND_LO, 32'h0304_0506);
      wr(`SEE_A_LEN, 32'h0000_0002);
      go(32'h0000_08D2);
      ck(`SEE_A_OPND_HI, 32'h0000_0304);
      ck(`SEE_A_OPND_LO, 32'h0506_0102);
      go(32'h0000_08D3);
      ck(`SEE_A_OPND_LO, 32'h0304_0506);
      wr(`SEE_A_LEN, 32'h0000_FFFF);
      wr(`SEE_A_SPTR, 32'h0000_0005);
      go(32'h0000_00D2);
      ck(`SEE_A_SPTR, 32'h0000_0005);
      wr(`SEE_A_LEN, 32'h0000_0001);
      wr(`SEE_A_DPTR, 32'h0000_0030);
      go(32'h0000_40DA);
      ck(`SEE_A_DPTR, 32'h0000_0031);
      wr(`SEE_A_LEN, 32'h0000_0003);
      wr(`SEE_A_DPTR, 32'h0000_0034);
      go(32'h0000_00DA);
      ck(`SEE_A_STATUS, 32'h0000_0100);
      wr(`SEE_A_STATUS, 32'h0000_1F18);
      wr(`SEE_A_DPTR, 32'h0000_0010);
      wr(`SEE_A_LEN, 32'h0000_0007);
      go(32'h0000_00DB);
      ck(`SEE_A_STATUS, 32'h0000_0100);
      ck(`SEE_A_DPTR, 32'h0008_0000);
      for (i = 0; i < 6; i = i + 1)
      begin
         wr(`SEE_A_STATUS, 32'h0000_1F18);
         go(fc[i]);
         ck(`SEE_A_STATUS, fe[i]);
      end
      `CK({31'h0, halt_o}, 32'h0)
      go(32'h0000_80DF);
      `CK({31'h0, halt_o}, 32'h1)
      wr(`SEE_A_STATUS, 32'h0000_0010);
      `CK({31'h0, halt_o}, 32'h0)
      wr(`SEE_A_SPTR, 32'h0000_0002);
      wr(`SEE_A_DPTR, 32'h0000_0013);
      wr(`SEE_A_LEN, 32'h0000_0001);
      go(32'h0000_00D6);
      go(32'h0000_00D0);
      ck(`SEE_A_STATUS, 32'h0000_0002);
      see_store_model_i.img[1] = 48'hF0F0_C1F1_F240;
      mc(6'h01);
      go(32'h0000_00D4);
      ck(`SEE_A_STATUS, 32'h0);
      go(32'h0001_02DE);
      ck(`SEE_A_RES_TOP, 32'h0000_0004);
      ck(`SEE_A_RES_SEC, 32'h0000_0015);
      ck(`SEE_A_STATUS, 32'h0000_0008);
      give_verdict;
   end
endmodule
